// ---- logic/vpf_front_end.sv ----
// pixel front end: clocks, pixel path, sync, register port
//
// Functional notes
// - pixel bus 32, 16, 8 or 4 bits
// - little or big endian pixel byte order
// - page register fills upper table address
// - 256 by 24 lookup table
// - true colour direct, leftover bits overlay
// - pass-through uses its own blanking input
// - pass-through forces first clock input
// - software picks dot clock, dual input
// - shift and video clocks divided
// - shift clock held low while blanked
// - normal sync active low, invertible
// - pass-through sync unchanged
// - select output low on pass-through code
// - control bit 7 later drives it high
// - flag rise in blank adds clock
// - nibble flag picks byte half
// - read starts on read strobe
// - write data stored on write strobe
// - four select lines pick register
// - six-bit mode shifts converter data
// - six-bit readback clears top bits
// - first clock input after reset
// - three bytes make one entry
// - table addresses wrap to zero
`default_nettype none
module vpf_front_end
  import vpf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [3:0]  registerSelect,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic [7:0]       rdData,
  // dot clock inputs, sampled as levels
  input  wire logic [2:0]  dotClkIn,
  input  wire logic        dualModeDotClockIn,
  input  wire logic        dualModeDotClockIn_n,
  // pixel sources and control inputs
  input  wire logic [31:0] pixelIn,
  input  wire logic [7:0]  passthroughPixelIn,
  input  wire logic        blankIn_n,
  input  wire logic        passthroughBlankingIn_n,
  input  wire logic        hsyncIn_n,
  input  wire logic        vsyncIn_n,
  input  wire logic        splitOrNibbleFlag,
  input  wire logic        resolution8,
  // outputs
  output vpf_rgb_s         dacData,
  output logic [7:0]       overlayOut,
  output logic             greenCurrentOutSync,
  output logic             shiftClkOut,
  output logic             videoClockOut,
  output logic             horizSyncDrive,
  output logic             vertSyncDrive,
  output logic             externalSelectOut
);
  // control registers
  logic [7:0]  maskReg;         // pixel read mask
  logic [7:0]  genReg;          // general control
  logic [7:0]  icsReg;          // input clock selection
  logic [7:0]  ocsReg;          // output clock selection
  logic [7:0]  muxReg;          // mux control
  logic [7:0]  pageReg;         // palette page
  logic [7:0]  testReg;         // test scratch
  // palette access state
  logic [7:0]  wAddr;           // write address counter
  logic [7:0]  rAddr;           // read address counter
  logic [7:0]  holdR;           // collected red
  logic [7:0]  holdG;           // collected green
  vpf_rgb_s    hold;            // readback holding
  vpf_phase_e  wPhase;          // write byte phase
  vpf_phase_e  rPhase;          // read byte phase
  // clocking
  logic        dotLvl;          // chosen clock level
  logic        dotPrev;         // previous level
  logic        dotEdge;         // one dot clock event
  logic [7:0]  dotCnt;          // divider counter
  logic        shiftNxt;        // next shift clock level
  logic        videoNxt;        // next video clock level
  vpf_split_e  splitSt;         // extra clock state
  logic        flagPrev;        // flag history
  logic        nibHigh;         // nibble sample
  // pixel path
  logic [31:0] wordIn;          // reordered pixel word
  logic [31:0] word;            // latched pixel word
  logic        passMode;        // pass-through active
  logic        blankAct;        // chosen blanking
  logic [7:0]  pixAddr;         // table address
  logic        useDirect;       // direct colour select
  vpf_rgb_s    directRgb;       // direct colour
  vpf_rgb_s    directR;         // staged direct colour
  logic        useDirectR;      // staged select
  logic        blankR;          // staged blank
  logic [7:0]  ovlR;            // staged overlay
  vpf_rgb_s    lutPix;          // table output
  vpf_rgb_s    lutCpu;          // table processor read
  logic        ramWe;           // table write
  logic        wrHit;           // write to select code
  logic [7:0]  cpuAddr;         // processor table address

  assign passMode = (muxReg == MUX_PASS);
  assign blankAct = passMode ? !passthroughBlankingIn_n : !blankIn_n;

  // six-bit converter mapping
  function automatic logic [7:0] toDac(input logic [7:0] v,
                                      input logic b8);
    toDac = b8 ? v : {v[5:0], 2'b00};
  endfunction

  // dot clock source choice, level sampled every clk
  always_comb
  begin
    dotLvl = dotClkIn[0];
    if (!passMode)
    begin
      case (vpf_clksrc_e'(icsReg[2:0]))
        CS_CLK0: dotLvl = dotClkIn[0];
        CS_CLK1: dotLvl = dotClkIn[1];
        CS_CLK2: dotLvl = dotClkIn[2];
        CS_DIFF: dotLvl = dualModeDotClockIn & !dualModeDotClockIn_n;
        CS_DPOS: dotLvl = dualModeDotClockIn;
        CS_DNEG: dotLvl = dualModeDotClockIn_n;
        default: dotLvl = dotClkIn[0];
      endcase
    end
  end

  // edge of the chosen dot clock
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dotPrev <= 1'b0;
      dotCnt  <= 8'h00;
    end
    else
    begin
      dotPrev <= dotLvl;
      if (dotEdge)
      begin
        dotCnt <= dotCnt + 8'h01;
      end
    end
  end
  assign dotEdge = dotLvl & !dotPrev;

  // divided clocks, shift clock gated by blanking
  always_comb
  begin
    videoNxt = dotCnt[ocsReg[2:0]];
    if (blankAct)
    begin
      shiftNxt = (splitSt == SP_HIGH);
    end
    else
    begin
      shiftNxt = dotCnt[ocsReg[5:3]];
    end
  end

  // extra shift clock cycle on flag rise during blank
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      splitSt  <= SP_IDLE;
      flagPrev <= 1'b0;
    end
    else
    begin
      flagPrev <= splitOrNibbleFlag;
      case (splitSt)
        SP_IDLE:
          if (splitOrNibbleFlag && !flagPrev && blankAct &&
              !genReg[GEN_NIB] && genReg[GEN_SPLIT])
          begin
            splitSt <= SP_HIGH;
          end
        SP_HIGH:
          if (dotEdge)
          begin
            splitSt <= SP_LOW;
          end
        SP_LOW:
          if (dotEdge)
          begin
            splitSt <= SP_IDLE;
          end
        default: splitSt <= SP_IDLE;
      endcase
    end
  end

  // byte order and nibble choice per byte
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_byte
      logic [7:0] bIn;
      assign bIn = genReg[GEN_BIGEND] ? pixelIn[8*(3-gb) +: 8]
                                      : pixelIn[8*gb +: 8];
      assign wordIn[8*gb +: 8] =
        (genReg[GEN_NIB] && !genReg[GEN_SPLIT]) ?
        {4'h0, (nibHigh ? bIn[7:4] : bIn[3:0])} : bIn;
    end
  endgenerate

  // clock outputs, nibble sample, pixel word latch
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shiftClkOut   <= 1'b0;
      videoClockOut <= 1'b0;
      nibHigh       <= 1'b0;
      word          <= 32'h0000_0000;
    end
    else
    begin
      shiftClkOut   <= shiftNxt;
      videoClockOut <= videoNxt;
      if (videoClockOut && !videoNxt)
      begin
        nibHigh <= splitOrNibbleFlag;
      end
      if (shiftNxt && !shiftClkOut)
      begin
        word <= wordIn;
      end
    end
  end

  // pixel slice, table address, direct colour
  always_comb
  begin
    logic [2:0] lgBus;
    logic [2:0] lgEl;
    logic [2:0] lgN;
    logic [7:0] idx;
    logic [7:0] elMask;
    logic [7:0] pix;
    logic [15:0] half;
    lgBus = 3'd5 - {1'b0, muxReg[1:0]};
    lgEl = 3'd3 - {1'b0, muxReg[3:2]};
    lgN = (lgBus > lgEl) ? lgBus - lgEl : 3'd0;
    idx = dotCnt & ~(8'hFF << lgN);
    pix = 8'(word >> (idx << lgEl));
    elMask = ~(8'hFF << (8'd1 << lgEl));
    half = (muxReg[1:0] == 2'h0 && dotCnt[0]) ? word[31:16]
                                              : word[15:0];
    directRgb = word[23:0];
    useDirect = 1'b0;
    pixAddr = (pix & elMask) | (pageReg & ~elMask);
    if (passMode)
    begin
      pixAddr = passthroughPixelIn;
    end
    else if (muxReg[5:4] == TC_24)
    begin
      pixAddr = word[31:24];
      useDirect = (word[31:24] == 8'h00);
    end
    else if (muxReg[5:4] == TC_555)
    begin
      pixAddr = {pageReg[7:1], half[15]};
      directRgb = {half[14:10], 3'h0, half[9:5], 3'h0,
                   half[4:0], 3'h0};
      useDirect = !half[15];
    end
    pixAddr = pixAddr & maskReg;
  end

  // lookup table
  vpf_palette_ram u_ram (
    .clk     (clk),
    .wrEn    (ramWe),
    .wrAddr  (wAddr),
    .wrData  ({holdR, holdG, wrData}),
    .cpuAddr (cpuAddr),
    .cpuData (lutCpu),
    .pixAddr (pixAddr),
    .pixData (lutPix)
  );

  // colour pipeline beside the table read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      directR    <= '0;
      useDirectR <= 1'b0;
      blankR     <= 1'b1;
      ovlR       <= 8'h00;
      dacData    <= '0;
      overlayOut <= 8'h00;
    end
    else
    begin
      directR    <= directRgb;
      useDirectR <= useDirect;
      blankR     <= blankAct;
      ovlR       <= pixAddr;
      overlayOut <= ovlR;
      if (blankR)
      begin
        dacData <= '0;
      end
      else if (useDirectR)
      begin
        dacData <= directR;
      end
      else
      begin
        dacData <= {toDac(lutPix.red, resolution8),
                    toDac(lutPix.green, resolution8),
                    toDac(lutPix.blue, resolution8)};
      end
    end
  end

  // sync handling
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      horizSyncDrive      <= 1'b1;
      vertSyncDrive       <= 1'b1;
      greenCurrentOutSync <= 1'b0;
    end
    else if (passMode)
    begin
      horizSyncDrive      <= hsyncIn_n;
      vertSyncDrive       <= vsyncIn_n;
      greenCurrentOutSync <= 1'b0;
    end
    else
    begin
      horizSyncDrive      <= hsyncIn_n ^ genReg[GEN_HINV];
      vertSyncDrive       <= vsyncIn_n ^ genReg[GEN_VINV];
      greenCurrentOutSync <= !hsyncIn_n || !vsyncIn_n;
    end
  end

  // register decode, strobes already in this clock domain
  assign wrHit = wrStb;
  assign ramWe = wrHit && registerSelect == REG_HOLD &&
                 wPhase == PH_BLUE;
  assign cpuAddr = (wrHit && registerSelect == REG_RADDR) ? wrData
                                                          : rAddr;

  // control register writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      maskReg <= RST_MASK;
      genReg  <= RST_ZERO;
      icsReg  <= RST_ZERO;
      ocsReg  <= RST_ZERO;
      muxReg  <= RST_ZERO;
      pageReg <= RST_ZERO;
      testReg <= RST_ZERO;
    end
    else if (wrHit)
    begin
      case (registerSelect)
        REG_MASK: maskReg <= wrData;
        REG_GEN:  genReg  <= wrData;
        REG_ICS:  icsReg  <= wrData;
        REG_OCS:  ocsReg  <= wrData;
        REG_MUX:  muxReg  <= wrData;
        REG_PAGE: pageReg <= wrData;
        REG_TEST: testReg <= wrData;
        default:  testReg <= testReg;
      endcase
    end
  end

  // external select pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      externalSelectOut <= 1'b1;
    end
    else if (wrHit && registerSelect == REG_MUX)
    begin
      externalSelectOut <= (wrData != MUX_PASS);
    end
    else if (wrHit && registerSelect == REG_GEN && passMode &&
             wrData[GEN_EXTSEL])
    begin
      externalSelectOut <= 1'b1;
    end
  end

  // palette write side
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wAddr  <= 8'h00;
      wPhase <= PH_RED;
      holdR  <= 8'h00;
      holdG  <= 8'h00;
    end
    else if (wrHit && registerSelect == REG_WADDR)
    begin
      wAddr  <= wrData;
      wPhase <= PH_RED;
    end
    else if (wrHit && registerSelect == REG_HOLD)
    begin
      case (wPhase)
        PH_RED:
        begin
          holdR  <= wrData;
          wPhase <= PH_GREEN;
        end
        PH_GREEN:
        begin
          holdG  <= wrData;
          wPhase <= PH_BLUE;
        end
        default:
        begin
          wAddr  <= wAddr + 8'h01;
          wPhase <= PH_RED;
        end
      endcase
    end
  end

  // palette read side
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rAddr  <= 8'h00;
      rPhase <= PH_RED;
      hold   <= '0;
    end
    else if (wrHit && registerSelect == REG_RADDR)
    begin
      hold   <= lutCpu;
      rAddr  <= wrData + 8'h01;
      rPhase <= PH_RED;
    end
    else if (rdStb && registerSelect == REG_HOLD)
    begin
      case (rPhase)
        PH_RED:   rPhase <= PH_GREEN;
        PH_GREEN: rPhase <= PH_BLUE;
        default:
        begin
          hold   <= lutCpu;
          rAddr  <= rAddr + 8'h01;
          rPhase <= PH_RED;
        end
      endcase
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData <= 8'h00;
    end
    else if (rdStb)
    begin
      case (registerSelect)
        REG_WADDR: rdData <= wAddr;
        REG_HOLD:
          case (rPhase)
            PH_RED:   rdData <= hold.red & {resolution8, resolution8,
                                            6'h3F};
            PH_GREEN: rdData <= hold.green & {resolution8, resolution8,
                                              6'h3F};
            default:  rdData <= hold.blue & {resolution8, resolution8,
                                             6'h3F};
          endcase
        REG_MASK:  rdData <= maskReg;
        REG_RADDR: rdData <= rAddr;
        REG_GEN:   rdData <= genReg;
        REG_ICS:   rdData <= icsReg;
        REG_OCS:   rdData <= ocsReg;
        REG_MUX:   rdData <= muxReg;
        REG_PAGE:  rdData <= pageReg;
        REG_TEST:  rdData <= testReg;
        default:   rdData <= 8'h00;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_blankGate;
    blankAct && splitSt == SP_IDLE |=> !shiftClkOut;
  endproperty
  a_blankGate: assert property (p_blankGate)
    else $error("shift clock not gated in blank");

  property p_passSync;
    passMode |=> horizSyncDrive == $past(hsyncIn_n);
  endproperty
  a_passSync: assert property (p_passSync)
    else $error("pass-through sync altered");

  property p_normSync;
    !passMode |=> vertSyncDrive ==
      ($past(vsyncIn_n) ^ $past(genReg[GEN_VINV]));
  endproperty
  a_normSync: assert property (p_normSync)
    else $error("normal sync polarity wrong");

  property p_extLow;
    wrStb && registerSelect == REG_MUX && wrData == MUX_PASS
      |=> !externalSelectOut;
  endproperty
  a_extLow: assert property (p_extLow)
    else $error("select output not low");

  property p_extHigh;
    wrStb && registerSelect == REG_GEN && passMode && wrData[7]
      |=> externalSelectOut;
  endproperty
  a_extHigh: assert property (p_extHigh)
    else $error("select output not high");

  property p_wrap;
    ramWe && wAddr == 8'hFF |=> wAddr == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("write address did not wrap");

  property p_rd6;
    rdStb && registerSelect == REG_HOLD && !resolution8
      |=> rdData[7:6] == 2'h0;
  endproperty
  a_rd6: assert property (p_rd6)
    else $error("six-bit readback top bits set");

  property p_clk0;
    passMode |-> dotLvl == dotClkIn[0];
  endproperty
  a_clk0: assert property (p_clk0)
    else $error("pass-through not on first clock");

  property p_rdPage;
    rdStb && registerSelect == REG_PAGE ##1 !wrStb[*1]
      |-> rdData == $past(pageReg);
  endproperty
  a_rdPage: assert property (p_rdPage)
    else $error("page readback wrong");
endmodule
`default_nettype wire

// ---- logic/vpf_pkg.sv ----
// shared constants and types of the palette pixel front end
`default_nettype none
package vpf_pkg;
  // register select codes
  localparam logic [3:0] REG_WADDR = 4'h0;
  localparam logic [3:0] REG_HOLD  = 4'h1;
  localparam logic [3:0] REG_MASK  = 4'h2;
  localparam logic [3:0] REG_RADDR = 4'h3;
  localparam logic [3:0] REG_GEN   = 4'h8;
  localparam logic [3:0] REG_ICS   = 4'h9;
  localparam logic [3:0] REG_OCS   = 4'hA;
  localparam logic [3:0] REG_MUX   = 4'hB;
  localparam logic [3:0] REG_PAGE  = 4'hC;
  localparam logic [3:0] REG_TEST  = 4'hE;
  // values after reset
  localparam logic [7:0] RST_MASK  = 8'hFF;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  // mux control code for pass-through
  localparam logic [7:0] MUX_PASS  = 8'h2D;
  // general control bit positions
  localparam int GEN_HINV   = 0;
  localparam int GEN_VINV   = 1;
  localparam int GEN_SPLIT  = 2;
  localparam int GEN_NIB    = 3;
  localparam int GEN_BIGEND = 4;
  localparam int GEN_EXTSEL = 7;
  // true-colour codes in mux control bits 5..4
  localparam logic [1:0] TC_24  = 2'h1;
  localparam logic [1:0] TC_555 = 2'h2;
  // dot clock sources
  typedef enum logic [2:0] {
    CS_CLK0 = 3'b000,
    CS_CLK1 = 3'b001,
    CS_CLK2 = 3'b010,
    CS_DIFF = 3'b011,
    CS_DPOS = 3'b100,
    CS_DNEG = 3'b101
  } vpf_clksrc_e;
  // extra shift clock cycle states
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_HIGH = 2'b01,
    SP_LOW  = 2'b10
  } vpf_split_e;
  // colour byte phase of the holding register
  typedef enum logic [1:0] {
    PH_RED   = 2'b00,
    PH_GREEN = 2'b01,
    PH_BLUE  = 2'b10
  } vpf_phase_e;
  // one colour entry
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vpf_rgb_s;
endpackage
`default_nettype wire

// ---- logic/vpf_palette_ram.sv ----
// colour lookup table, 256 entries of 24 bits
`default_nettype none
module vpf_palette_ram
  import vpf_pkg::*;
(
  // clock
  input  wire logic     clk,
  // processor side
  input  wire logic     wrEn,
  input  wire logic [7:0] wrAddr,
  input  wire vpf_rgb_s wrData,
  input  wire logic [7:0] cpuAddr,
  output vpf_rgb_s      cpuData,
  // pixel side
  input  wire logic [7:0] pixAddr,
  output vpf_rgb_s      pixData
);
  // table storage, no reset on purpose
  vpf_rgb_s lut [0:255];

  // write port and registered pixel read
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      lut[wrAddr] <= wrData;
    end
    pixData <= lut[pixAddr];
  end

  // holding register loads in the same edge
  assign cpuData = lut[cpuAddr];
endmodule
`default_nettype wire

// ---- verif/vpf_pixel_source.sv ----
// video memory serial port and dot clock model feeding the front end
`default_nettype none
module vpf_pixel_source
  import vpf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // from the front end and the bench
  input  wire logic        shiftClkOut,
  input  wire logic        flagReq,
  // dot clocks
  output logic [2:0]       dotClkIn,
  output logic             dualP,
  output logic             dualN,
  // pixel data and flag
  output logic [31:0]      pixelIn,
  output logic [7:0]       ptPixel,
  output logic             flag
);
  logic shiftPrev; // last shift clock level
  // only the first input runs; the others stand still
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dotClkIn <= 3'h0;
      dualP    <= 1'b0;
      dualN    <= 1'b1;
    end
    else
    begin
      dotClkIn[0] <= ~dotClkIn[0];
      dualP       <= 1'b0;
      dualN       <= 1'b1;
    end
  end
  // serial port moves to next word after each shift clock rise
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shiftPrev <= 1'b0;
      pixelIn   <= 32'h0;
      ptPixel   <= 8'h0;
      flag      <= 1'b0;
    end
    else
    begin
      shiftPrev <= shiftClkOut;
      flag      <= flagReq;
      ptPixel   <= pixelIn[7:0];
      if (shiftClkOut && !shiftPrev)
        pixelIn <= pixelIn + 32'h01010101;
    end
  end
endmodule
`default_nettype wire

// ---- verif/vpf_front_end_bench.sv ----
// bench for the palette pixel front end
`default_nettype none
module vpf_front_end_bench
  import vpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, wrStb, rdStb, dualP, dualN, flag, flagReq, res8;
  logic blank_n, ptBlank_n, hs_n, vs_n, gsync, sclk, video_clock_out, hOut, vOut;
  logic extSel, sPrev, vPrev;
  logic [3:0]  sel;            // register select
  logic [7:0]  wd, rd_q, ptPix, ovl;
  logic [2:0]  dclk;
  logic [31:0] pix;
  vpf_rgb_s    dac;
  int mismatches, nChecks, sR, vR, cyc;
  logic [7:0] bytes [9] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
    8'h77, 8'h88, 8'h99};

  vpf_front_end dut_u (.clk(clk), .arst_n(arst_n), .registerSelect(sel),
    .wrData(wd), .wrStb(wrStb), .rdStb(rdStb), .rdData(rd_q),
    .dotClkIn(dclk), .dualModeDotClockIn(dualP),
    .dualModeDotClockIn_n(dualN), .pixelIn(pix), .passthroughPixelIn(ptPix),
    .blankIn_n(blank_n), .passthroughBlankingIn_n(ptBlank_n),
    .hsyncIn_n(hs_n), .vsyncIn_n(vs_n), .splitOrNibbleFlag(flag),
    .resolution8(res8), .dacData(dac), .overlayOut(ovl),
    .greenCurrentOutSync(gsync), .shiftClkOut(sclk), .videoClockOut(video_clock_out),
    .horizSyncDrive(hOut), .vertSyncDrive(vOut),
    .externalSelectOut(extSel));
  vpf_pixel_source src_u (.clk(clk), .arst_n(arst_n), .shiftClkOut(sclk),
    .flagReq(flagReq), .dotClkIn(dclk), .dualP(dualP), .dualN(dualN),
    .pixelIn(pix), .ptPixel(ptPix), .flag(flag));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // clock edge counters and hang guard
  always @(posedge clk)
  begin
    sPrev <= sclk;
    vPrev <= video_clock_out;
    if (sclk && !sPrev) sR++;
    if (video_clock_out && !vPrev) vR++;
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // compare and report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wrStb <= 1'b1;
    sel   <= a;
    wd    <= d;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  // one-cycle register read, data looked at in the next cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rdStb <= 1'b1;
    sel   <= a;
    @(posedge clk);
    rdStb <= 1'b0;
    @(negedge clk);
    check(32'(rd_q), 32'(exp));
  endtask
  // count clock rises over n cycles
  task automatic count(input int n);
    @(negedge clk);
    sR = 0;
    vR = 0;
    repeat (n) @(negedge clk);
  endtask
  // verdict
  task automatic finish_test();
    if (mismatches == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {arst_n, wrStb, rdStb, flagReq, hs_n, vs_n} = 6'b000011;
    {res8, blank_n, ptBlank_n, sel, wd} = {3'b111, 4'h0, 8'h00};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(REG_MASK, RST_MASK);
    rd(REG_GEN, RST_ZERO);
    wr(4'h5, 8'hA5);
    rd(4'h5, 8'h00);
    wr(REG_PAGE, 8'h5A);
    rd(REG_PAGE, 8'h5A);
    // block write from entry FE round to entry zero
    wr(REG_WADDR, 8'hFE);
    for (int i = 0; i < 9; i++) wr(REG_HOLD, bytes[i]);
    wr(REG_RADDR, 8'hFF);
    for (int i = 3; i < 9; i++) rd(REG_HOLD, bytes[i]);
    @(posedge clk) res8 <= 1'b0;
    wr(REG_RADDR, 8'h00);
    for (int i = 6; i < 9; i++) rd(REG_HOLD, bytes[i] & 8'h3F);
    // one bit-plane, mask drops the pixel bit, page picks the entry
    wr(REG_PAGE, 8'h00);
    wr(REG_MUX, 8'h0C);
    wr(REG_MASK, 8'hFE);
    count(4);
    check(32'(dac), {8'h00, bytes[6][5:0], 2'h0, bytes[7][5:0], 2'h0,
      bytes[8][5:0], 2'h0});
    check(32'(ovl), 32'h0);
    @(posedge clk) res8 <= 1'b1;
    wr(REG_PAGE, 8'hFF);
    count(4);
    check(32'(dac), {8'h00, bytes[0], bytes[1], bytes[2]});
    check(32'(ovl), 32'hFE);
    wr(REG_MASK, 8'hFF);
    wr(REG_MUX, 8'h00);
    // divided clocks, blanking, source choice
    count(64);
    check(32'(sR), 32'h10);
    check(32'(vR), 32'h10);
    check(32'(sR > 0), 32'h1);
    // shift clock on the next divider bit, settle before counting
    wr(REG_OCS, 8'h08);
    count(8);
    count(64);
    check(32'(sR), 32'h8);
    check(32'(vR), 32'h10);
    @(posedge clk) blank_n <= 1'b0;
    count(8);
    count(64);
    check(32'(sR), 32'h0);
    wr(REG_ICS, 8'h01);
    count(8);
    count(64);
    check(32'(vR), 32'h0);
    wr(REG_ICS, 8'h00);
    // split transfer, then flag ignored
    wr(REG_GEN, 8'h04);
    count(8);
    @(posedge clk) flagReq <= 1'b1;
    count(32);
    check(32'(sR), 32'h1);
    wr(REG_GEN, 8'h00);
    @(posedge clk) flagReq <= 1'b0;
    count(8);
    @(posedge clk) flagReq <= 1'b1;
    count(32);
    check(32'(sR), 32'h0);
    // sync polarity and pass-through
    @(posedge clk) hs_n <= 1'b0;
    count(4);
    check(32'(hOut), 32'h0);
    check(32'(gsync), 32'h1);
    check(32'(vOut), 32'h1);
    check(32'(extSel), 32'h1);
    wr(REG_GEN, 8'h01);
    count(4);
    check(32'(hOut), 32'h1);
    // idle second input chosen, so only a forced first input runs
    wr(REG_ICS, 8'h01);
    wr(REG_MUX, MUX_PASS);
    count(4);
    check(32'(hOut), 32'h0);
    check(32'(extSel), 32'h0);
    count(64);
    check(32'(sR > 0), 32'h1);
    @(posedge clk) ptBlank_n <= 1'b0;
    count(8);
    count(64);
    check(32'(sR), 32'h0);
    wr(REG_GEN, 8'h81);
    count(4);
    check(32'(extSel), 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
